// ### logic/sgd_dma.v
// Descriptor-driven scatter-gather DMA engine with register slave and memory master.
`timescale 1ns/100ps
`default_nettype none
`include "sgd_regs.vh"
module sgd_dma #(
  parameter CHW = 4
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Register slave.
  input wire [3:0] csr_address,
  input wire csr_read,
  input wire csr_write,
  input wire [31:0] csr_writedata,
  output reg [31:0] csr_readdata,
  output wire csr_waitrequest,
  // Interrupt.
  output wire irq,
  // Memory master for descriptors and data.
  output reg [31:0] mem_address,
  output reg mem_read,
  output reg mem_write,
  output reg [31:0] mem_writedata,
  input wire [31:0] mem_readdata,
  input wire mem_waitrequest,
  // Stream source.
  output reg src_valid,
  input wire src_ready,
  output reg [31:0] src_data,
  output reg src_sop,
  output reg src_eop,
  output reg [CHW-1:0] src_channel,
  // Stream sink.
  input wire snk_valid,
  output wire snk_ready,
  input wire [31:0] snk_data,
  input wire snk_eop,
  input wire [CHW-1:0] snk_channel,
  input wire [7:0] snk_error
);
  localparam S_IDLE = 8'h01;
  localparam S_FETCH = 8'h02;
  localparam S_CHECK = 8'h04;
  localparam S_POLL = 8'h08;
  localparam S_RD = 8'h10;
  localparam S_WR = 8'h20;
  localparam S_WB = 8'h40;
  localparam S_NEXT = 8'h80;

  reg [7:0] state;
  reg csr_ack;
  reg [31:0] ctl;
  reg [3:0] sts;
  reg [3:0] mask;
  reg [31:0] cur_ptr;
  reg [31:0] d_raddr;
  reg [31:0] d_waddr;
  reg [31:0] d_next;
  reg [15:0] d_len;
  reg [7:0] d_ctrl;
  reg [2:0] idx;
  reg [31:0] raddr;
  reg [31:0] waddr;
  reg [15:0] count;
  reg [7:0] errs;
  reg [31:0] word;
  reg [CHW-1:0] chan;
  reg first;
  reg lastw;
  reg sawe;
  reg [7:0] poll_cnt;
  reg [3:0] set_ev;
  reg parked;

  wire mem_done = (mem_read | mem_write) & ~mem_waitrequest;
  wire src_is_stream = (d_raddr == 32'h00000000);
  wire dst_is_stream = (d_waddr == 32'h00000000);
  wire [15:0] count_next = count + `SGD_BYTES_PER_WORD;
  wire len_hit = (d_len != 16'h0000) && (count_next >= d_len);
  wire [7:0] ivl = ctl[`SGD_CTL_IVL_LO+7:`SGD_CTL_IVL_LO];
  wire csr_rd_acc = csr_read & csr_ack;
  wire csr_wr_acc = csr_write & csr_ack;

  assign csr_waitrequest = (csr_read | csr_write) & ~csr_ack;
  assign snk_ready = (state == S_RD) && src_is_stream;
  assign irq = |(sts & mask);

  // Register slave: one wait cycle, then the answer.
  always @(posedge clk) begin
    if (rst) begin
      csr_ack <= 1'b0;
      csr_readdata <= 32'h00000000;
      ctl <= 32'h00000000;
      mask <= 4'h0;
    end else begin
      csr_ack <= (csr_read | csr_write) & ~csr_ack;
      // Read data is loaded in the wait cycle so it stands at the completing edge.
      if (csr_read && !csr_ack) begin
        case (csr_address)
          `SGD_CSR_CONTROL: csr_readdata <= ctl;
          `SGD_CSR_STATUS: csr_readdata <= {27'h0000000, state != S_IDLE, sts};
          `SGD_CSR_MASK: csr_readdata <= {28'h0000000, mask};
          `SGD_CSR_DESC_PTR: csr_readdata <= cur_ptr;
          default: csr_readdata <= 32'h00000000;
        endcase
      end
      if (csr_wr_acc && csr_address == `SGD_CSR_CONTROL) begin
        ctl <= csr_writedata;
      end
      if (csr_wr_acc && csr_address == `SGD_CSR_MASK) begin
        mask <= csr_writedata[3:0];
      end
    end
  end

  // Sticky status: a read clears only the bits it reported, and new events win.
  always @(posedge clk) begin
    if (rst) begin
      sts <= 4'h0;
    end else if (csr_rd_acc && csr_address == `SGD_CSR_STATUS) begin
      sts <= (sts & ~csr_readdata[3:0]) | set_ev;
    end else begin
      sts <= sts | set_ev;
    end
  end

  // Descriptor walker and data mover.
  always @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      cur_ptr <= 32'h00000000;
      d_raddr <= 32'h00000000;
      d_waddr <= 32'h00000000;
      d_next <= 32'h00000000;
      d_len <= 16'h0000;
      d_ctrl <= 8'h00;
      idx <= 3'h0;
      raddr <= 32'h00000000;
      waddr <= 32'h00000000;
      count <= 16'h0000;
      errs <= 8'h00;
      word <= 32'h00000000;
      chan <= {CHW{1'b0}};
      first <= 1'b0;
      lastw <= 1'b0;
      sawe <= 1'b0;
      poll_cnt <= 8'h00;
      set_ev <= 4'h0;
      parked <= 1'b0;
      mem_address <= 32'h00000000;
      mem_read <= 1'b0;
      mem_write <= 1'b0;
      mem_writedata <= 32'h00000000;
      src_valid <= 1'b0;
      src_data <= 32'h00000000;
      src_sop <= 1'b0;
      src_eop <= 1'b0;
      src_channel <= {CHW{1'b0}};
    end else begin
      set_ev <= 4'h0;
      // A stopped chain restarts only after software writes the control register.
      if (csr_wr_acc && csr_address == `SGD_CSR_CONTROL) begin
        parked <= 1'b0;
      end
      case (state)
        S_IDLE: begin
          if (csr_wr_acc && csr_address == `SGD_CSR_DESC_PTR) begin
            cur_ptr <= csr_writedata;
          end
          if (ctl[`SGD_CTL_RUN] && !parked) begin
            idx <= 3'h0;
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (!mem_read) begin
            mem_read <= 1'b1;
            mem_address <= cur_ptr + {27'h0000000, idx, 2'b00};
          end else if (mem_done) begin
            mem_read <= 1'b0;
            case (idx)
              `SGD_W_READ_ADDR: d_raddr <= mem_readdata;
              `SGD_W_WRITE_ADDR: d_waddr <= mem_readdata;
              `SGD_W_NEXT: d_next <= mem_readdata;
              `SGD_W_LENGTH: d_len <= mem_readdata[15:0];
              `SGD_W_RESULT: d_ctrl <= mem_readdata[31:24];
              default: d_len <= d_len;
            endcase
            idx <= idx + 3'h1;
            if (idx == `SGD_W_RESULT) begin
              state <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          if (d_ctrl[`SGD_C_OWNER]) begin
            raddr <= d_raddr;
            waddr <= d_waddr;
            count <= 16'h0000;
            errs <= 8'h00;
            sawe <= 1'b0;
            first <= 1'b1;
            chan <= d_ctrl[`SGD_C_CHAN_LO+CHW-1:`SGD_C_CHAN_LO];
            state <= S_RD;
          end else if (ctl[`SGD_CTL_POLL]) begin
            poll_cnt <= (ivl == 8'h00) ? 8'h01 : ivl;
            state <= S_POLL;
          end else begin
            set_ev[`SGD_ST_CHAIN_DONE] <= 1'b1;
            parked <= 1'b1;
            state <= S_IDLE;
          end
        end
        S_POLL: begin
          if (poll_cnt == 8'h01) begin
            idx <= 3'h0;
            state <= S_FETCH;
          end else begin
            poll_cnt <= poll_cnt - 8'h01;
          end
        end
        S_RD: begin
          if (src_is_stream) begin
            if (snk_valid) begin
              word <= snk_data;
              chan <= snk_channel;
              errs <= errs | snk_error;
              sawe <= snk_eop;
              lastw <= snk_eop | len_hit;
              state <= S_WR;
            end
          end else if (!mem_read) begin
            mem_read <= 1'b1;
            mem_address <= raddr;
          end else if (mem_done) begin
            mem_read <= 1'b0;
            word <= mem_readdata;
            lastw <= len_hit;
            if (!d_ctrl[`SGD_C_HOLD_READ]) begin
              raddr <= raddr + 32'h00000004;
            end
            state <= S_WR;
          end
        end
        S_WR: begin
          if (dst_is_stream) begin
            if (!src_valid) begin
              src_valid <= 1'b1;
              src_data <= word;
              src_sop <= first & d_ctrl[`SGD_C_HOLD_WRITE];
              src_eop <= lastw & d_ctrl[`SGD_C_END_MARKER];
              src_channel <= chan;
            end else if (src_ready) begin
              src_valid <= 1'b0;
              src_sop <= 1'b0;
              src_eop <= 1'b0;
              count <= count_next;
              first <= 1'b0;
              state <= lastw ? S_WB : S_RD;
            end
          end else if (!mem_write) begin
            mem_write <= 1'b1;
            mem_address <= waddr;
            mem_writedata <= word;
          end else if (mem_done) begin
            mem_write <= 1'b0;
            if (!d_ctrl[`SGD_C_HOLD_WRITE]) begin
              waddr <= waddr + 32'h00000004;
            end
            count <= count_next;
            first <= 1'b0;
            state <= lastw ? S_WB : S_RD;
          end
        end
        S_WB: begin
          if (!mem_write) begin
            mem_write <= 1'b1;
            mem_address <= cur_ptr + `SGD_RESULT_OFFSET;
            // Ownership is returned to software; the channel is the one last seen.
            mem_writedata <= {1'b0, chan, d_ctrl[2:0], errs, count};
          end else if (mem_done) begin
            mem_write <= 1'b0;
            set_ev[`SGD_ST_DESC_DONE] <= 1'b1;
            set_ev[`SGD_ST_ERROR] <= (errs != 8'h00);
            set_ev[`SGD_ST_EOP] <= sawe;
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          cur_ptr <= d_next;
          idx <= 3'h0;
          if (ctl[`SGD_CTL_RUN]) begin
            state <= S_FETCH;
          end else begin
            set_ev[`SGD_ST_CHAIN_DONE] <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // sgd_dma
`default_nettype wire

// ### include/sgd_regs.vh
// Register offsets, field positions and descriptor layout of the descriptor DMA.
`ifndef SGD_REGS_VH
`define SGD_REGS_VH
`define SGD_CSR_CONTROL 4'h0
`define SGD_CSR_STATUS 4'h4
`define SGD_CSR_MASK 4'h8
`define SGD_CSR_DESC_PTR 4'hc
`define SGD_CTL_RUN 0
`define SGD_CTL_POLL 1
`define SGD_CTL_IVL_LO 8
`define SGD_ST_ERROR 0
`define SGD_ST_EOP 1
`define SGD_ST_DESC_DONE 2
`define SGD_ST_CHAIN_DONE 3
`define SGD_ST_BUSY 4
`define SGD_DESC_WORDS 4'h8
`define SGD_W_READ_ADDR 3'h0
`define SGD_W_WRITE_ADDR 3'h2
`define SGD_W_NEXT 3'h4
`define SGD_W_LENGTH 3'h6
`define SGD_W_RESULT 3'h7
`define SGD_RESULT_OFFSET 32'h0000001c
`define SGD_BYTES_PER_WORD 16'h0004
`define SGD_C_END_MARKER 0
`define SGD_C_HOLD_READ 1
`define SGD_C_HOLD_WRITE 2
`define SGD_C_CHAN_LO 3
`define SGD_C_OWNER 7
`endif

// ### verif/sgd_dma_asserts.sv
// Concurrent checks on the descriptor DMA ports.
`timescale 1ns/100ps
`default_nettype none
module sgd_dma_asserts #(
  parameter CHW = 4
) (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Watched signals.
  input wire irq,
  input wire [31:0] mem_address,
  input wire mem_read,
  input wire mem_write,
  input wire [31:0] mem_writedata,
  input wire mem_waitrequest,
  input wire src_valid,
  input wire src_ready,
  input wire [31:0] src_data,
  input wire src_sop,
  input wire src_eop,
  input wire [CHW-1:0] src_channel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_mem_rd_hold: assert property (
    mem_read && mem_waitrequest |=> mem_read && $stable(mem_address)) else $error("read moved");
  a_mem_wr_hold: assert property (
    mem_write && mem_waitrequest |=> mem_write && $stable(mem_writedata)) else $error("write moved");
  a_mem_idle_gap: assert property (
    (mem_read || mem_write) && !mem_waitrequest |=> !mem_read && !mem_write) else $error("no gap");
  a_wb_owner: assert property (
    mem_write && mem_address[4:0] == 5'h1c |-> !mem_writedata[31]) else $error("owner kept");
  a_irq_after_wb: assert property (
    $rose(irq) |-> !mem_write) else $error("irq before write-back");
  a_src_hold: assert property (
    src_valid && !src_ready |=> src_valid && $stable({src_data, src_sop, src_eop, src_channel}))
    else $error("stream word moved");
  a_src_gap: assert property (
    src_valid && src_ready |=> !src_valid) else $error("stream word repeated");
  a_src_no_wr: assert property (
    src_valid |-> !mem_write) else $error("memory write with stream out");
endmodule // sgd_dma_asserts
bind sgd_dma sgd_dma_asserts #(.CHW(CHW)) i_chk (
  .clk(clk), .rst(rst), .irq(irq), .mem_address(mem_address), .mem_read(mem_read),
  .mem_write(mem_write), .mem_writedata(mem_writedata), .mem_waitrequest(mem_waitrequest),
  .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data), .src_sop(src_sop),
  .src_eop(src_eop), .src_channel(src_channel)
);
`default_nettype wire

// ### verif/sgd_mem_model.sv
// Descriptor memory and stream endpoints facing the descriptor DMA.
`timescale 1ns/100ps
`default_nettype none
module sgd_mem_model (
  // Clock and pacing.
  input wire clk,
  input wire slow,
  input wire [7:0] eop_at,
  // Memory slave.
  input wire [31:0] mem_address,
  input wire mem_read,
  input wire mem_write,
  input wire [31:0] mem_writedata,
  output logic [31:0] mem_readdata,
  output logic mem_waitrequest,
  // Stream endpoints.
  output logic src_ready,
  output logic snk_valid,
  output logic [31:0] snk_data,
  output logic snk_eop,
  output logic [3:0] snk_channel,
  output logic [7:0] snk_error,
  input wire snk_ready
);
  logic [31:0] m [0:63];
  logic [7:0] cnt = 8'h00;
  logic [7:0] k = 8'h01;
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    if (mem_write && !mem_waitrequest) begin
      m[mem_address[7:2]] <= mem_writedata;
    end
    if (snk_valid && snk_ready) begin
      k <= k + 8'h01;
    end
  end
  assign mem_waitrequest = slow & cnt[0];
  assign mem_readdata = (mem_read && !mem_waitrequest) ? m[mem_address[7:2]] : {4{~cnt}};
  assign src_ready = !slow | cnt[1];
  assign snk_valid = 1'b1;
  assign snk_data = {24'h0, k};
  assign snk_eop = (k == eop_at);
  assign snk_channel = k[3:0] + 4'h2;
  assign snk_error = 8'h01 << k[2:0];
endmodule // sgd_mem_model
`default_nettype wire

// ### verif/sgd_dma_tb.sv
// Self-checking bench for the descriptor DMA.
`timescale 1ns/100ps
`default_nettype none
module sgd_dma_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] csr_address = 4'h0;
  logic csr_read = 1'b0;
  logic csr_write = 1'b0;
  logic [31:0] csr_writedata = 32'h0;
  logic [31:0] q;
  wire [31:0] csr_readdata, mem_address, mem_writedata, mem_readdata, src_data, snk_data;
  wire csr_waitrequest, irq, mem_read, mem_write, mem_waitrequest, src_valid, src_ready;
  wire src_sop, src_eop, snk_valid, snk_ready, snk_eop;
  wire [3:0] src_channel, snk_channel;
  wire [7:0] snk_error;
  int failures = 0;
  int comparisons = 0;
  int nsrc = 0;
  always #20 clk = ~clk;
  sgd_dma i_dut (.clk(clk), .rst(rst), .csr_address(csr_address), .csr_read(csr_read),
    .csr_write(csr_write), .csr_writedata(csr_writedata), .csr_readdata(csr_readdata),
    .csr_waitrequest(csr_waitrequest), .irq(irq), .mem_address(mem_address),
    .mem_read(mem_read), .mem_write(mem_write), .mem_writedata(mem_writedata),
    .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest), .src_valid(src_valid),
    .src_ready(src_ready), .src_data(src_data), .src_sop(src_sop), .src_eop(src_eop),
    .src_channel(src_channel), .snk_valid(snk_valid), .snk_ready(snk_ready),
    .snk_data(snk_data), .snk_eop(snk_eop), .snk_channel(snk_channel), .snk_error(snk_error));
  sgd_mem_model i_mem (.clk(clk), .slow(1'b1), .eop_at(8'h03), .mem_address(mem_address),
    .mem_read(mem_read), .mem_write(mem_write), .mem_writedata(mem_writedata),
    .mem_readdata(mem_readdata), .mem_waitrequest(mem_waitrequest), .src_ready(src_ready),
    .snk_valid(snk_valid), .snk_data(snk_data), .snk_eop(snk_eop), .snk_channel(snk_channel),
    .snk_error(snk_error), .snk_ready(snk_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic csr(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    csr_address <= a;
    csr_write <= w;
    csr_read <= !w;
    csr_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (!csr_waitrequest) break;
    end
    q = csr_readdata;
    csr_read <= 1'b0;
    csr_write <= 1'b0;
    chk(n < 20, 1'b1);
    if (n == 20) finish_test();
  endtask
  task automatic desc(input int b, input logic [31:0] rd, wr, nx, input logic [15:0] len,
                      input logic [7:0] ctl);
    i_mem.m[b] = rd;
    i_mem.m[b+1] = 32'h0;
    i_mem.m[b+2] = wr;
    i_mem.m[b+3] = 32'h0;
    i_mem.m[b+4] = nx;
    i_mem.m[b+5] = 32'h0;
    i_mem.m[b+6] = {16'h0, len};
    i_mem.m[b+7] = {ctl, 24'h0};
  endtask
  always @(posedge clk) if (src_valid && src_ready) begin
    chk({src_sop, src_eop, src_channel}, {nsrc == 0, nsrc == 2, 4'h9});
    chk(src_data, 32'h1234abcd);
    nsrc++;
  end
  initial begin
    int n;
    i_mem.m[32] = 32'h1234abcd;
    i_mem.m[33] = 32'h55aa0f0f;
    i_mem.m[53] = 32'h0;
    desc(0, 32'h80, 32'hc0, 32'h20, 16'h8, 8'h80);
    desc(8, 32'h0, 32'hd0, 32'h40, 16'h0, 8'h84);
    desc(16, 32'h80, 32'h0, 32'h60, 16'hc, 8'hcf);
    desc(24, 32'h0, 32'h0, 32'h0, 16'h4, 8'h00);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    csr(1'b1, 4'h8, 32'h8);
    csr(1'b1, 4'hc, 32'h0);
    csr(1'b1, 4'h0, 32'h1);
    for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
    chk(n < 4000, 1'b1);
    if (n == 4000) finish_test();
    chk(i_mem.m[48], 32'h1234abcd);
    chk(i_mem.m[49], 32'h55aa0f0f);
    chk(i_mem.m[52], 32'h3);
    chk(i_mem.m[53], 32'h0);
    chk({i_mem.m[7][31:24], i_mem.m[7][15:0]}, 32'h8);
    chk(i_mem.m[15], 32'h2c0e000c);
    chk({i_mem.m[23][31:24], i_mem.m[23][15:0]}, 32'h4f000c);
    chk(i_mem.m[31], 32'h0);
    chk(nsrc, 3);
    csr(1'b0, 4'hc, 32'h0);
    chk(q, 32'h60);
    csr(1'b1, 4'h8, 32'h0);
    @(posedge clk);
    chk(irq, 1'b0);
    csr(1'b1, 4'h8, 32'h8);
    @(posedge clk);
    chk(irq, 1'b1);
    csr(1'b0, 4'h4, 32'h0);
    chk(q[4:1], 4'h7);
    @(posedge clk);
    chk(irq, 1'b0);
    csr(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    i_mem.m[56] = 32'h0;
    desc(24, 32'h80, 32'he0, 32'h60, 16'h4, 8'h00);
    csr(1'b1, 4'h8, 32'h4);
    csr(1'b1, 4'h0, 32'h303);
    repeat (100) @(posedge clk);
    chk(irq, 1'b0);
    chk(i_mem.m[56], 32'h0);
    csr(1'b0, 4'h4, 32'h0);
    chk(q[4], 1'b1);
    i_mem.m[31] = 32'h80000000;
    for (n = 0; n < 1000 && irq !== 1'b1; n++) @(posedge clk);
    chk(n < 1000, 1'b1);
    if (n == 1000) finish_test();
    chk(i_mem.m[56], 32'h1234abcd);
    chk(i_mem.m[31], 32'h4);
    finish_test();
  end
endmodule // sgd_dma_tb
`default_nettype wire
